// ==== logic/hbdf_cfg_decode.sv ====
// settings decode from the selection pin level or the two-bit field
`timescale 1ns/10ps
`default_nettype none
module hbdf_cfg_decode (
    // selection
    input  wire logic             spiVariant,
    input  wire logic             independentMode,
    input  wire logic [2:0]       pinLevel,
    input  wire logic [1:0]       fieldValue,
    // decoded settings
    output hbdf_pkg::hbdf_cfg_s   cfg
);
    import hbdf_pkg::*;
    always_comb begin
        cfg = '0;
        if (spiVariant) begin
            cfg.retryReact = 1'b0;
            if (!independentMode) begin
                cfg.offCheckEn = (fieldValue != 2'h0);
                cfg.onCheckAvail = 1'b1;
                cfg.regulationAvail = 1'b1;
            end else begin
                cfg.offCheckEn = fieldValue[0];
                cfg.highSideLoad = fieldValue[1];
                cfg.onCheckAvail = fieldValue[1];
                cfg.regulationAvail = !fieldValue[1];
            end
        end else begin
            cfg.onCheckAvail = 1'b0;
            if (!independentMode) begin
                cfg.offCheckEn = !(pinLevel == LVL1 || pinLevel == LVL5);
                cfg.retryReact = (pinLevel == LVL1);
                cfg.regulationAvail = 1'b1;
            end else begin
                cfg.highSideLoad = (pinLevel == LVL3 || pinLevel == LVL4);
                cfg.regulationAvail = !cfg.highSideLoad;
                cfg.offCheckEn = !(pinLevel == LVL1 || pinLevel == LVL5);
                cfg.retryReact = (pinLevel == LVL1 || pinLevel == LVL4
                    || pinLevel == LVL6);
            end
        end
    end
endmodule // hbdf_cfg_decode
`default_nettype wire

// ==== logic/hbdf_fault_ctrl.sv ====
// h-bridge diagnostic setup decode and fault handling top
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// - pin variant decodes the selection input as one of six levels
// - full-bridge pin: level1 no check retry, level5 no check latch, else check latch
// - independent pin: load side, regulation, check and reaction per level
// - pin level latched at init after reset or sleep wake, ignored afterwards
// - spi full-bridge: field 00 disables off check; on check always available
// - spi independent: field bit1 high side, bit0 off check enable
// - field writes take effect immediately
// - any fault pulls the open-drain error output low, except in the standby off-check case
// - sleep releases the error output
// - spi: error output is inverse summary bit, except locked off-check case
// - spi: overcurrent or overtemperature fault is logged into summary and status registers; off-state only into standby status
// - logs clear only by clear command or sleep request
// - one 16-bit frame returns active or standby status
// - overcurrent above threshold longer than filter time is a fault
// - overcurrent disables both outputs, or only affected half in independent mode
// - high-side overcurrent keeps current mirror pulled to its limit
// - overcurrent reaction is latched or retry with wait and clear times
// - spi: overcurrent threshold and filter time come from setup register
// - overtemperature above threshold longer than filter time is a fault
// - overtemperature reaction latched or retry after hysteresis and clear time
// - pin variant: off-state comparator shown on error output in standby when check enabled
module hbdf_fault_ctrl (
    // clock and reset
    input  wire logic                 clk,
    input  wire logic                 reset_n,
    // variant and mode
    input  wire logic                 spiVariant,
    input  wire logic                 independentMode,
    input  wire logic                 activeState,
    input  wire logic                 spiInLocked,
    // pins from the host
    input  wire logic [2:0]           load_check_select_pin,
    input  wire logic                 sleep_request_n,
    // serial setup
    input  wire logic [1:0]           load_check_select_field,
    input  wire logic [3:0]           setup_reg_d,
    input  wire logic                 clear_errors_cmd,
    // analog comparators
    input  wire logic [1:0]           overcurrentAbove,
    input  wire logic [1:0]           overcurrentHighSide,
    input  wire logic                 thermalAbove,
    input  wire logic                 offstateCmp,
    // outputs
    output logic                      error_out_n_o,
    output logic                      error_out_n_oe,
    output logic [1:0]                halfBridgeHiZ,
    output logic                      mirrorPullLimit,
    output logic                      mirrorHiZ,
    output logic [1:2]                ocpThresholdSel,
    output logic [2:0]                ocpThreshold,
    output hbdf_pkg::hbdf_cfg_s       cfgOut,
    output hbdf_pkg::hbdf_log_s       logOut,
    output logic [15:0]               statusFrame
);
    import hbdf_pkg::*;

    // pin synchronisers
    logic [2:0] pinMeta_r, pinSync_r;
    logic [1:0] sleepSync_r;
    logic [1:0] ocMeta_r, ocSync_r, hsMeta_r, hsSync_r;
    logic       thMeta_r, thSync_r, olMeta_r, olSync_r;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pinMeta_r <= 3'h0;
            pinSync_r <= 3'h0;
            sleepSync_r <= 2'h0;
            ocMeta_r <= 2'h0;
            ocSync_r <= 2'h0;
            hsMeta_r <= 2'h0;
            hsSync_r <= 2'h0;
            thMeta_r <= 1'b0;
            thSync_r <= 1'b0;
            olMeta_r <= 1'b0;
            olSync_r <= 1'b0;
        end else begin
            pinMeta_r <= load_check_select_pin;
            pinSync_r <= pinMeta_r;
            sleepSync_r <= {sleepSync_r[0], sleep_request_n};
            ocMeta_r <= overcurrentAbove;
            ocSync_r <= ocMeta_r;
            hsMeta_r <= overcurrentHighSide;
            hsSync_r <= hsMeta_r;
            thMeta_r <= thermalAbove;
            thSync_r <= thMeta_r;
            olMeta_r <= offstateCmp;
            olSync_r <= olMeta_r;
        end
    end
    logic asleep;
    assign asleep = !sleepSync_r[1];

    // level latched once per wake; later pin moves are ignored
    logic [2:0] levelHeld_r, levelHeld_nxt;
    logic       levelValid_r, levelValid_nxt;
    always_comb begin
        levelHeld_nxt = levelHeld_r;
        levelValid_nxt = levelValid_r;
        if (asleep) begin
            levelValid_nxt = 1'b0;
        end else if (!levelValid_r) begin
            levelHeld_nxt = pinSync_r;
            levelValid_nxt = 1'b1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            levelHeld_r <= LVL1;
            levelValid_r <= 1'b0;
        end else begin
            levelHeld_r <= levelHeld_nxt;
            levelValid_r <= levelValid_nxt;
        end
    end

    // field value is used live, no staging
    hbdf_cfg_s cfg;
    hbdf_cfg_decode uDecode (
        .spiVariant      (spiVariant),
        .independentMode (independentMode),
        .pinLevel        (levelHeld_r),
        .fieldValue      (load_check_select_field),
        .cfg             (cfg)
    );
    assign cfgOut = cfg;

    // overcurrent filter from setup_reg_d bits 1:0, threshold from bits 3:2
    function automatic logic [CNT_W-1:0] ocpFilter(input logic [1:0] sel);
        case (sel)
            2'h0: ocpFilter = CNT_W'((OCP_FILT0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            2'h1: ocpFilter = CNT_W'((OCP_FILT1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            2'h2: ocpFilter = CNT_W'((OCP_FILT2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
            default: ocpFilter = CNT_W'((OCP_FILT3_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
        endcase
    endfunction
    logic [CNT_W-1:0] ocFilt;
    assign ocFilt = spiVariant ? ocpFilter(setup_reg_d[1:0]) : ocpFilter(2'h3);
    assign ocpThresholdSel = spiVariant ? setup_reg_d[3:2] : 2'h3;
    assign ocpThreshold = {1'b0, ocpThresholdSel};

    logic clearReq;
    assign clearReq = clear_errors_cmd || asleep;

    // overcurrent per half bridge, only watched while active
    logic [1:0] ocTrip, ocPulse;
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gOcp
            hbdf_trip_timer uOcp (
                .clk        (clk),
                .reset_n    (reset_n),
                .cond       (ocSync_r[g] && activeState),
                .filterCyc  (ocFilt),
                .waitCyc    (CNT_W'(RETRY_WAIT_CYC)),
                .clearCyc   (CNT_W'(ERROR_CLEAR_CYC)),
                .retryReact (cfg.retryReact),
                .clearReq   (clearReq),
                .tripped    (ocTrip[g]),
                .tripPulse  (ocPulse[g])
            );
        end
    endgenerate

    // thermal: sensor comparator already includes hysteresis
    logic thTrip, thPulse;
    hbdf_trip_timer uTsd (
        .clk        (clk),
        .reset_n    (reset_n),
        .cond       (thSync_r && !asleep),
        .filterCyc  (CNT_W'(THERMAL_FILTER_CYC)),
        .waitCyc    (CNT_W'(1)),
        .clearCyc   (CNT_W'(THERMAL_CLEAR_CYC)),
        .retryReact (cfg.retryReact),
        .clearReq   (clearReq),
        .tripped    (thTrip),
        .tripPulse  (thPulse)
    );

    // output disables
    always_comb begin
        if (thTrip) halfBridgeHiZ = 2'h3;
        else if (independentMode) halfBridgeHiZ = ocTrip;
        else halfBridgeHiZ = {2{|ocTrip}};
    end
    assign mirrorHiZ = thTrip;
    assign mirrorPullLimit = !thTrip && |(ocTrip & hsSync_r);

    // fault log; a new event wins over a same-cycle clear
    hbdf_log_s log_r, log_nxt;
    logic [ST_W-1:0] evActive, evStandby;
    always_comb begin
        evActive = '0;
        evStandby = '0;
        evActive[ST_OCP1] = ocPulse[0];
        evActive[ST_OCP2] = ocPulse[1];
        evActive[ST_TSD] = thPulse && activeState;
        evStandby[ST_TSD] = thPulse && !activeState;
        evStandby[ST_OLP] = olSync_r && cfg.offCheckEn && !activeState;
        log_nxt = log_r;
        if (clearReq) log_nxt = '{1'b0, ST_RESET, ST_RESET};
        log_nxt.activeStatus = log_nxt.activeStatus | evActive;
        log_nxt.standbyStatus = log_nxt.standbyStatus | evStandby;
        if (|{ocPulse, thPulse}) log_nxt.errorSummary = 1'b1;
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) log_r <= '{1'b0, ST_RESET, ST_RESET};
        else log_r <= log_nxt;
    end
    assign logOut = log_r;

    // one frame: summary plus whichever status fits the state
    assign statusFrame = {log_r.errorSummary, 7'h00,
        activeState ? log_r.activeStatus : log_r.standbyStatus};

    // open-drain error output
    logic pullLow_r, pullLow_nxt;
    always_comb begin
        if (asleep) pullLow_nxt = 1'b0;
        else if (!activeState && cfg.offCheckEn && (!spiVariant || spiInLocked))
            pullLow_nxt = !olSync_r;
        else if (spiVariant) pullLow_nxt = log_nxt.errorSummary;
        else pullLow_nxt = |{ocTrip, thTrip};
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) pullLow_r <= 1'b0;
        else pullLow_r <= pullLow_nxt;
    end
    assign error_out_n_o = 1'b0;
    assign error_out_n_oe = pullLow_r;
endmodule // hbdf_fault_ctrl
`default_nettype wire

// ==== logic/hbdf_pkg.sv ====
// package: constants and carrier types for the h-bridge diagnostic and fault block
package hbdf_pkg;
    // timing figures and derived cycle counts at 125 MHz
    localparam int CLK_MHZ = 125;
    localparam int RETRY_WAIT_US = 4;
    localparam int RETRY_WAIT_CYC = RETRY_WAIT_US * CLK_MHZ;
    localparam int ERROR_CLEAR_US = 2;
    localparam int ERROR_CLEAR_CYC = ERROR_CLEAR_US * CLK_MHZ;
    localparam int THERMAL_FILTER_US = 1;
    localparam int THERMAL_FILTER_CYC = THERMAL_FILTER_US * CLK_MHZ;
    localparam int THERMAL_CLEAR_US = 4;
    localparam int THERMAL_CLEAR_CYC = THERMAL_CLEAR_US * CLK_MHZ;
    // overcurrent filter time choices, in ns, selected by setup_reg_d
    localparam int OCP_FILT0_NS = 600;
    localparam int OCP_FILT1_NS = 1200;
    localparam int OCP_FILT2_NS = 2400;
    localparam int OCP_FILT3_NS = 4800;
    localparam int CLK_PERIOD_NS = 8;
    localparam int CNT_W = 12;
    // selection pin levels, one to six
    localparam logic [2:0] LVL1 = 3'h1;
    localparam logic [2:0] LVL2 = 3'h2;
    localparam logic [2:0] LVL3 = 3'h3;
    localparam logic [2:0] LVL4 = 3'h4;
    localparam logic [2:0] LVL5 = 3'h5;
    localparam logic [2:0] LVL6 = 3'h6;
    // status bit positions
    localparam int ST_OCP1 = 0;
    localparam int ST_OCP2 = 1;
    localparam int ST_TSD = 2;
    localparam int ST_OLP = 3;
    localparam int ST_W = 8;
    localparam logic [ST_W-1:0] ST_RESET = 8'h00;

    typedef struct packed {
        logic offCheckEn;
        logic highSideLoad;
        logic retryReact;
        logic onCheckAvail;
        logic regulationAvail;
    } hbdf_cfg_s;

    typedef struct packed {
        logic errorSummary;
        logic [ST_W-1:0] activeStatus;
        logic [ST_W-1:0] standbyStatus;
    } hbdf_log_s;

    typedef enum logic [1:0] {OCP_RUN, OCP_HOLD, OCP_WAIT, OCP_CLEAR} hbdf_trip_e;
endpackage

// ==== logic/hbdf_trip_timer.sv ====
// filtered trip detector with latch or timed retry recovery
`timescale 1ns/10ps
`default_nettype none
module hbdf_trip_timer (
    // clock and reset
    input  wire logic                    clk,
    input  wire logic                    reset_n,
    // control
    input  wire logic                    cond,
    input  wire logic [11:0]             filterCyc,
    input  wire logic [11:0]             waitCyc,
    input  wire logic [11:0]             clearCyc,
    input  wire logic                    retryReact,
    input  wire logic                    clearReq,
    // result
    output logic                         tripped,
    output logic                         tripPulse
);
    import hbdf_pkg::*;
    hbdf_trip_e  state_r, state_nxt;
    logic [CNT_W-1:0] cnt_r, cnt_nxt;

    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        tripPulse = 1'b0;
        case (state_r)
            OCP_RUN: begin
                if (!cond) begin
                    cnt_nxt = '0;
                end else if (cnt_r >= filterCyc) begin
                    state_nxt = retryReact ? OCP_WAIT : OCP_HOLD;
                    cnt_nxt = '0;
                    tripPulse = 1'b1;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
            OCP_HOLD: begin
                if (clearReq && !cond) begin
                    state_nxt = OCP_RUN;
                    cnt_nxt = '0;
                end
            end
            OCP_WAIT: begin
                // condition must be gone before retry count begins
                if (cond || cnt_r < waitCyc) cnt_nxt = cond ? '0 : cnt_r + 1'b1;
                else begin
                    state_nxt = OCP_CLEAR;
                    cnt_nxt = '0;
                end
            end
            default: begin
                if (cond) begin
                    state_nxt = OCP_WAIT;
                    cnt_nxt = '0;
                end else if (cnt_r >= clearCyc) begin
                    state_nxt = OCP_RUN;
                    cnt_nxt = '0;
                end else begin
                    cnt_nxt = cnt_r + 1'b1;
                end
            end
        endcase
        if (clearReq && !cond && state_r != OCP_RUN) begin
            state_nxt = OCP_RUN;
            cnt_nxt = '0;
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= OCP_RUN;
            cnt_r <= '0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign tripped = (state_r != OCP_RUN);
endmodule // hbdf_trip_timer
`default_nettype wire

// ==== sim/hbdf_fault_monitor.sv ====
// concurrent checks on the fault control top ports
`timescale 1ns/10ps
`default_nettype none
module hbdf_fault_monitor (
    // clock and reset
    input  wire logic                clk,
    input  wire logic                reset_n,
    // inputs watched
    input  wire logic                spiVariant,
    input  wire logic                independentMode,
    input  wire logic                activeState,
    input  wire logic                spiInLocked,
    input  wire logic                sleep_request_n,
    input  wire logic [1:0]          load_check_select_field,
    input  wire logic                clear_errors_cmd,
    // outputs watched
    input  wire logic                error_out_n_o,
    input  wire logic                error_out_n_oe,
    input  wire logic [1:0]          halfBridgeHiZ,
    input  wire logic                mirrorHiZ,
    input  wire hbdf_pkg::hbdf_cfg_s cfgOut,
    input  wire hbdf_pkg::hbdf_log_s logOut,
    input  wire logic [15:0]         statusFrame
);
    import hbdf_pkg::*;
    logic [2:0] sinceClr_r;
    logic [2:0] sinceClr_nxt;
    // sleep passes two sync stages and clear a log register, so allow a short lag
    always_comb begin
        sinceClr_nxt = sinceClr_r;
        if (clear_errors_cmd || !sleep_request_n) begin
            sinceClr_nxt = 3'h0;
        end else if (sinceClr_r != 3'h7) begin
            sinceClr_nxt = sinceClr_r + 3'h1;
        end
    end
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            sinceClr_r <= 3'h7;
        end else begin
            sinceClr_r <= sinceClr_nxt;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    od_drive_low_a: assert property (error_out_n_o == 1'b0)
        else $error("error pin drives a high level");
    sleep_release_a: assert property ($fell(sleep_request_n) |-> ##[1:4] !error_out_n_oe)
        else $error("error pin not released in sleep");
    field_full_a: assert property (spiVariant && !independentMode |->
        cfgOut.offCheckEn == (load_check_select_field != 2'h0) && cfgOut.onCheckAvail)
        else $error("full bridge field decode wrong");
    field_indep_a: assert property (spiVariant && independentMode |->
        {cfgOut.offCheckEn, cfgOut.highSideLoad, cfgOut.onCheckAvail, cfgOut.regulationAvail}
        == {load_check_select_field[0], load_check_select_field[1],
        load_check_select_field[1], !load_check_select_field[1]})
        else $error("independent field decode wrong");
    thermal_both_a: assert property ($rose(mirrorHiZ) |-> halfBridgeHiZ == 2'h3)
        else $error("thermal trip left an output driven");
    pin_follows_a: assert property (spiVariant && !(cfgOut.offCheckEn && spiInLocked)
        && $stable(spiVariant) |-> ##1 error_out_n_oe == logOut.errorSummary)
        else $error("error pin differs from summary bit");
    log_on_fault_a: assert property (spiVariant && $rose(error_out_n_oe) |-> logOut.errorSummary)
        else $error("fault signalled without log entry");
    log_hold_a: assert property ($fell(logOut.errorSummary) |-> sinceClr_r < 3'h5)
        else $error("log cleared without clear or sleep");
    frame_map_a: assert property (statusFrame == {logOut.errorSummary, 7'h00, activeState ?
        logOut.activeStatus : logOut.standbyStatus})
        else $error("status frame layout wrong");
endmodule // hbdf_fault_monitor
bind hbdf_fault_ctrl hbdf_fault_monitor i_mon (.clk(clk), .reset_n(reset_n),
    .spiVariant(spiVariant), .independentMode(independentMode), .activeState(activeState),
    .spiInLocked(spiInLocked), .sleep_request_n(sleep_request_n),
    .load_check_select_field(load_check_select_field), .clear_errors_cmd(clear_errors_cmd),
    .error_out_n_o(error_out_n_o), .error_out_n_oe(error_out_n_oe),
    .halfBridgeHiZ(halfBridgeHiZ), .mirrorHiZ(mirrorHiZ), .cfgOut(cfgOut), .logOut(logOut),
    .statusFrame(statusFrame));
`default_nettype wire

// ==== sim/hbdf_host_model.sv ====
// host side model: pull-up on the open-drain error line
`timescale 1ns/10ps
`default_nettype none
module hbdf_host_model (
    // error pin from the device
    input  wire logic error_out_n_o,
    input  wire logic error_out_n_oe,
    // resolved wire level seen by the host
    output logic      errorLine
);
    // released line floats up to the pull-up, never the last driven value
    assign errorLine = error_out_n_oe ? error_out_n_o : 1'b1;
endmodule // hbdf_host_model
`default_nettype wire

// ==== sim/tb.sv ====
// testbench for the h-bridge diagnostic setup and fault block
`timescale 1ns/10ps
`default_nettype none
module tb;
    import hbdf_pkg::*;
    logic clk = 1'b0, reset_n = 1'b0, spiV = 1'b0, indep = 1'b0, active = 1'b1, locked = 1'b0;
    logic [2:0] pin = LVL1;
    logic sleepN = 1'b1, clr = 1'b0, therm = 1'b0, offCmp = 1'b1;
    logic [1:0] field = 2'h0, ocAbove = 2'h0, ocHigh = 2'h0, hiz;
    logic [3:0] setupD = 4'h0;
    logic odO, odOe, errLine, pullLim, mirHiz;
    hbdf_cfg_s cfg;
    hbdf_log_s lg;
    logic [15:0] frame;
    int mismatches = 0, total_checks = 0;
    always #4 clk = ~clk;
    hbdf_fault_ctrl i_dut (.clk(clk), .reset_n(reset_n), .spiVariant(spiV),
        .independentMode(indep), .activeState(active), .spiInLocked(locked),
        .load_check_select_pin(pin), .sleep_request_n(sleepN), .load_check_select_field(field),
        .setup_reg_d(setupD), .clear_errors_cmd(clr), .overcurrentAbove(ocAbove),
        .overcurrentHighSide(ocHigh), .thermalAbove(therm), .offstateCmp(offCmp),
        .error_out_n_o(odO), .error_out_n_oe(odOe), .halfBridgeHiZ(hiz),
        .mirrorPullLimit(pullLim), .mirrorHiZ(mirHiz), .ocpThresholdSel(), .ocpThreshold(),
        .cfgOut(cfg), .logOut(lg), .statusFrame(frame));
    hbdf_host_model i_host (.error_out_n_o(odO), .error_out_n_oe(odOe), .errorLine(errLine));
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic test_done;
        if (mismatches == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic waitHiz(input logic [1:0] e, input int n);
        int i;
        for (i = 0; i < n && hiz !== e; i++) tick(1);
        if (hiz !== e) begin
            chk(16'(hiz), 16'(e));
            test_done();
        end
    endtask
    task automatic wake;
        sleepN = 1'b0;
        tick(3);
        sleepN = 1'b1;
        tick(8);
    endtask
    // pin level tables, full bridge and independent
    task automatic chkPin(input int l);
        logic off, rty, hs;
        off = !(l == 1 || l == 5);
        hs = (l == 3 || l == 4);
        rty = indep ? (l == 1 || l == 4 || l == 6) : (l == 1);
        if (indep) chk(16'({cfg.offCheckEn, cfg.highSideLoad, cfg.retryReact,
            cfg.regulationAvail}), 16'({off, hs, rty, !hs}));
        else chk(16'({cfg.offCheckEn, cfg.retryReact}), 16'({off, rty}));
    endtask
    initial begin
        tick(8);
        reset_n = 1'b1;
        for (int m = 0; m < 2; m++) begin
            for (int l = 1; l <= 6; l++) begin
                indep = m[0];
                pin = 3'(l);
                wake();
                chkPin(l);
                if (indep && (l == 3 || l == 4)) chk(16'(cfg.offCheckEn), 16'h0001);
                pin = 3'(l % 6 + 1);
                tick(6);
                chkPin(l);
            end
        end
        // retry recovery, pin level one full bridge
        indep = 1'b0;
        pin = LVL1;
        wake();
        ocAbove = 2'h1;
        waitHiz(2'h3, 700);
        tick(1);
        chk(16'(errLine), 16'h0000);
        ocAbove = 2'h0;
        tick(400);
        chk(16'(hiz), 16'h0003);
        waitHiz(2'h0, 600);
        // standby comparator on the error pin, check enabled at level two
        pin = LVL2;
        wake();
        active = 1'b0;
        offCmp = 1'b0;
        tick(4);
        chk(16'(errLine), 16'h0000);
        offCmp = 1'b1;
        tick(4);
        chk(16'(errLine), 16'h0001);
        chk(frame, 16'h0008);
        active = 1'b1;
        // serial variant, every field value in both modes
        sleepN = 1'b0;
        tick(4);
        spiV = 1'b1;
        sleepN = 1'b1;
        tick(8);
        for (int k = 0; k < 8; k++) begin
            indep = k[2];
            field = k[1:0];
            tick(1);
            chk(16'(cfg.offCheckEn), 16'(k[1:0] != 2'h0 && !indep || indep && k[0]));
        end
        // filtered overcurrent, independent high side
        indep = 1'b1;
        field = 2'h3;
        setupD = 4'h1;
        ocAbove = 2'h1;
        tick(100);
        ocAbove = 2'h0;
        tick(4);
        chk(16'(hiz), 16'h0000);
        ocAbove = 2'h1;
        ocHigh = 2'h1;
        waitHiz(2'h1, 300);
        chk(16'(pullLim), 16'h0001);
        tick(2);
        chk(16'(frame[15] & frame[ST_OCP1]), 16'h0001);
        chk(16'(errLine), 16'h0000);
        ocAbove = 2'h0;
        tick(800);
        chk(16'({hiz, lg.errorSummary}), 16'h0003);
        clr = 1'b1;
        tick(2);
        clr = 1'b0;
        tick(4);
        chk(16'({hiz, lg.errorSummary, errLine}), 16'h0001);
        // thermal trip then sleep release
        therm = 1'b1;
        waitHiz(2'h3, 300);
        chk(16'(mirHiz), 16'h0001);
        therm = 1'b0;
        sleepN = 1'b0;
        tick(6);
        chk(16'({errLine, lg.errorSummary}), 16'h0002);
        sleepN = 1'b1;
        tick(4);
        test_done();
    end
endmodule // tb
`default_nettype wire
